// File: design/usbhtx_ctrl.sv
// Purpose: host-mode transmit endpoint control and status with the
//          endpoint 0 NAK limit, reached over classic Wishbone
// Assumes: link engine events are one-cycle pulses on ref_clk
// Notes: interrupt status/clear/enable words, bits 0 ep0, 1..3 ep1..3
`timescale 1ns/1ps
`default_nettype none

module usbhtx_ctrl #(
  parameter int AW = 12,
  parameter int NAK_LIMIT_MAX = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // endpoint 0 link events
  input wire logic frame_tick,
  input wire logic ep0_nak_rx,
  input wire logic ep0_other_rx,
  output logic ep0_halt,
  // endpoints 1..3 link events and controls
  input wire usbhtx_pkg::usbhtx_evt_s [usbhtx_pkg::NEP-1:0] ep_evt,
  output usbhtx_pkg::usbhtx_ctl_s [usbhtx_pkg::NEP-1:0] ep_ctl,
  // interrupt
  output logic irq
);

  // ==========================================================
  // checks
  initial begin
    if (AW < usbhtx_pkg::IW + 2) begin
      $error("address too narrow for register map");
    end
    if (NAK_LIMIT_MAX != 16) begin
      $error("frame counter is sized for a limit of 16");
    end
    if (usbhtx_pkg::CNTW < NAK_LIMIT_MAX) begin
      $error("frame counter narrower than the largest span");
    end
    if (usbhtx_pkg::NEP != 3) begin
      $error("interrupt words are packed for three endpoints");
    end
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic nak_to;
    logic toggle;
    logic stalled;
    logic setup;
    logic error;
    logic ready;
    // packets queued in the FIFO, two at most when double-buffered
    logic [1:0] pkts;
    // attempts without handshake for the packet at the head
    logic [1:0] tries;
    usbhtx_pkg::usbhtx_ctl_s ctl;
  } usbhtx_ep_s;

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [usbhtx_pkg::LIMW-1:0] limit;
    logic [usbhtx_pkg::CNTW-1:0] nak_frames;
    // a NAK arrived in the frame now running
    logic nak_seen;
    logic halt;
    // interrupt status and enable, bit 0 for endpoint 0
    logic [usbhtx_pkg::NEP:0] sts;
    logic [usbhtx_pkg::NEP:0] en;
    usbhtx_ep_s [usbhtx_pkg::NEP-1:0] ep;
  } usbhtx_state_s;

  usbhtx_state_s state_reg;
  usbhtx_state_s state_next;

  // ==========================================================
  // functions
  // frames allowed before halt for a limit value m
  function automatic logic [usbhtx_pkg::CNTW-1:0] lim_frames(
    input logic [usbhtx_pkg::LIMW-1:0] m
  );
    logic [usbhtx_pkg::LIMW-1:0] mm;
    // values above the top of the range act as the top value
    mm = (m > usbhtx_pkg::LIM_MAX) ? usbhtx_pkg::LIM_MAX : m;
    lim_frames = usbhtx_pkg::CNTW'(1) << (mm - 5'h01);
  endfunction

  // write-zero-to-clear flag; set is applied later and wins
  function automatic logic w0c(input logic cur, input logic wr,
                               input logic wbit);
    w0c = (wr && !wbit) ? 1'b0 : cur;
  endfunction

  // low byte of the control/status word
  function automatic logic [7:0] csr_byte(input usbhtx_ep_s e);
    csr_byte = usbhtx_pkg::RST_REG;
    csr_byte[usbhtx_pkg::B_NAK_TIMEOUT_FLAG] = e.nak_to;
    csr_byte[usbhtx_pkg::B_STALLED] = e.stalled;
    csr_byte[usbhtx_pkg::B_SETUP] = e.setup;
    csr_byte[usbhtx_pkg::B_ERROR] = e.error;
    csr_byte[usbhtx_pkg::B_FIFO_HAS_PACKET] = (e.pkts != 2'h0);
    csr_byte[usbhtx_pkg::B_READY] = e.ready;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic acc;
    logic wr;
    logic [usbhtx_pkg::IW-1:0] idx;
    logic [7:0] d;
    logic [usbhtx_pkg::NEP:0] ev_irq;
    logic wsel;
    logic nak_frame;
    logic [1:0] cap;
    usbhtx_ep_s e;
    usbhtx_pkg::usbhtx_evt_s ev;
    acc = 1'b0;
    wr = 1'b0;
    idx = '0;
    d = 8'h00;
    ev_irq = '0;
    wsel = 1'b0;
    nak_frame = 1'b0;
    cap = 2'h1;
    e = '0;
    ev = '0;
    state_next = state_reg;
    state_next.ack = 1'b0;

    // bus access: one wait state, answer registered; a write lands
    // at the edge where the master sees ack, while the request still
    // stands, so a request that never sees ack changes nothing
    acc = wb_cyc_i && wb_stb_i && !state_reg.ack;
    wr = wb_cyc_i && wb_stb_i && state_reg.ack && wb_we_i &&
         wb_sel_i[0];
    idx = wb_adr_i[usbhtx_pkg::IW+1:2];
    d = wb_dat_i[7:0];
    if (acc) begin
      state_next.ack = 1'b1;
      state_next.rdat = 8'h00;
      if (idx == usbhtx_pkg::IDX_NAK_LIMIT) begin
        state_next.rdat = {3'h0, state_reg.limit};
      end else if (idx == usbhtx_pkg::IDX_TX[0]) begin
        state_next.rdat = csr_byte(state_reg.ep[0]);
      end else if (idx == usbhtx_pkg::IDX_TX[1]) begin
        state_next.rdat = csr_byte(state_reg.ep[1]);
      end else if (idx == usbhtx_pkg::IDX_TX[2]) begin
        state_next.rdat = csr_byte(state_reg.ep[2]);
      end else if (idx == usbhtx_pkg::IDX_IRQ_STS) begin
        state_next.rdat = {4'h0, state_reg.sts};
      end else if (idx == usbhtx_pkg::IDX_IRQ_EN) begin
        state_next.rdat = {4'h0, state_reg.en};
      end
    end

    // endpoint 0 limit and NAK frame counting; a new limit restarts
    // the count and releases a halted endpoint, but a NAK frame closing in the same cycle is still judged on the old count and limit
    if (wr && idx == usbhtx_pkg::IDX_NAK_LIMIT) begin
      state_next.limit = d[usbhtx_pkg::LIMW-1:0];
      state_next.halt = 1'b0;
      state_next.nak_frames = '0;
    end
    // the tick closes a frame, so a NAK in the tick cycle still counts
    nak_frame = state_reg.nak_seen || ep0_nak_rx;
    if (ep0_other_rx) begin
      state_next.nak_frames = '0;
      state_next.nak_seen = 1'b0;
    end else if (frame_tick) begin
      state_next.nak_seen = 1'b0;
      if (!nak_frame) begin
        state_next.nak_frames = '0;
      end else if (state_reg.limit < usbhtx_pkg::LIM_MIN) begin
        state_next.nak_frames = '0;
      end else if (state_reg.nak_frames ==
                   lim_frames(state_reg.limit)) begin
        // the count holds here, so each further NAK frame re-raises
        // the status bit until a frame without NAK, another handshake or a new limit clears the count
        state_next.halt = 1'b1;
        ev_irq[0] = 1'b1;
      end else begin
        state_next.nak_frames = state_reg.nak_frames +
                                usbhtx_pkg::CNTW'(1);
      end
    end else if (ep0_nak_rx) begin
      state_next.nak_seen = 1'b1;
    end

    // endpoints 1..3, limits from their own interval logic
    for (int i = 0; i < usbhtx_pkg::NEP; i++) begin
      e = state_reg.ep[i];
      ev = ep_evt[i];
      wsel = wr && (idx == usbhtx_pkg::IDX_TX[i]);
      cap = ev.double_buf ? 2'h2 : 2'h1;
      e.ctl.flush_one = 1'b0;
      e.ctl.flush_all = 1'b0;
      e.ctl.abort_load = 1'b0;
      e.ctl.dma_stop = 1'b0;
      // an acknowledged packet flips the toggle; a clear below wins
      if (ev.ack_ok) begin
        e.toggle = ~e.toggle;
      end

      // software side: clears first, so hardware sets win
      e.nak_to = w0c(e.nak_to, wsel, d[usbhtx_pkg::B_NAK_TIMEOUT_FLAG]);
      e.stalled = w0c(e.stalled, wsel, d[usbhtx_pkg::B_STALLED]);
      e.error = w0c(e.error, wsel, d[usbhtx_pkg::B_ERROR]);
      if (wsel) begin
        e.setup = d[usbhtx_pkg::B_SETUP];
        if (d[usbhtx_pkg::B_TOGGLE_CLEAR] || d[usbhtx_pkg::B_SETUP]) begin
          e.toggle = 1'b0;
        end
        // flush with ready set aborts the packet being loaded, so the
        // count of queued packets stays as it is
        if (d[usbhtx_pkg::B_FLUSH]) begin
          e.ctl.flush_one = 1'b1;
          e.ready = 1'b0;
          ev_irq[i+1] = 1'b1;
          if (d[usbhtx_pkg::B_READY]) begin
            e.ctl.abort_load = 1'b1;
          end else if (e.pkts != 2'h0) begin
            e.pkts = e.pkts - 2'h1;
          end
        end else if (d[usbhtx_pkg::B_READY] && !e.ready &&
                     e.pkts < cap) begin
          e.ready = 1'b1;
          e.pkts = e.pkts + 2'h1;
        end
      end

      // hardware side; a double-buffered FIFO frees ready at once so
      // that software can queue the second packet behind the first
      if (e.ready && ev.double_buf && e.pkts == 2'h1) begin
        e.ready = 1'b0;
      end
      // a done report with nothing queued is stale and ignored
      if (ev.tx_done && e.pkts != 2'h0) begin
        e.pkts = e.pkts - 2'h1;
        e.ready = 1'b0;
        e.setup = 1'b0;
        e.tries = 2'h0;
        ev_irq[i+1] = 1'b1;
      end
      // attempts count per packet; a sent packet restarts the count
      if (ev.no_handshake && ev.bulk_int_mode) begin
        if (e.tries == usbhtx_pkg::TRY_LAST) begin
          e.error = 1'b1;
          e.tries = 2'h0;
          e.ready = 1'b0;
          e.pkts = 2'h0;
          e.ctl.flush_all = 1'b1;
          ev_irq[i+1] = 1'b1;
        end else begin
          e.tries = e.tries + 2'h1;
        end
      end
      // a stall empties the FIFO whatever else this cycle brought
      if (ev.stall_rx) begin
        e.stalled = 1'b1;
        e.ctl.dma_stop = 1'b1;
        e.ctl.flush_all = 1'b1;
        e.ready = 1'b0;
        e.pkts = 2'h0;
        e.tries = 2'h0;
        ev_irq[i+1] = 1'b1;
      end
      if (ev.bulk_nak_timeout || ev.hb_no_response) begin
        e.nak_to = 1'b1;
        ev_irq[i+1] = 1'b1;
      end
      // ready stays stored but is masked on the link while nak_to stands
      e.ctl.packet_ready = e.ready && !e.nak_to;
      e.ctl.setup_token = e.setup;
      e.ctl.data_toggle = e.toggle;
      state_next.ep[i] = e;
    end

    // interrupt status: write-one clear, event set wins
    // (enable is plain read/write; status itself ignores writes)
    if (wr && idx == usbhtx_pkg::IDX_IRQ_EN) begin
      state_next.en = d[usbhtx_pkg::NEP:0];
    end
    if (wr && idx == usbhtx_pkg::IDX_IRQ_CLR) begin
      state_next.sts = state_next.sts & ~d[usbhtx_pkg::NEP:0];
    end
    state_next.sts = state_next.sts | ev_irq;
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign wb_ack_o = state_reg.ack;
  // register byte rides in the low lane, upper lanes read zero
  assign wb_dat_o = {24'h000000, state_reg.rdat};
  assign ep0_halt = state_reg.halt;
  assign irq = |(state_reg.sts & state_reg.en);
  always_comb begin
    for (int i = 0; i < usbhtx_pkg::NEP; i++) begin
      ep_ctl[i] = state_reg.ep[i].ctl;
    end
  end

endmodule

`default_nettype wire

// File: design/usbhtx_pkg.sv
// Purpose: shared constants and carriers of the host transmit endpoint
//          control block
// Assumes: 32-bit classic Wishbone, register index = byte address / 4
// Notes: one 8-bit register per word, low byte lane only
package usbhtx_pkg;

  // ==========================================================
  // sizes
  localparam int NEP = 3;
  localparam int IW = 9;
  localparam int LIMW = 5;
  localparam int CNTW = 16;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [IW-1:0] IDX_NAK_LIMIT = 9'h10b;
  localparam logic [IW-1:0] IDX_TX [NEP] = '{9'h112, 9'h122, 9'h132};
  localparam logic [IW-1:0] IDX_IRQ_STS = 9'h140;
  localparam logic [IW-1:0] IDX_IRQ_CLR = 9'h141;
  localparam logic [IW-1:0] IDX_IRQ_EN = 9'h142;

  // ==========================================================
  // control/status low byte fields
  localparam int B_NAK_TIMEOUT_FLAG = 7;
  localparam int B_TOGGLE_CLEAR = 6;
  localparam int B_STALLED = 5;
  localparam int B_SETUP = 4;
  localparam int B_FLUSH = 3;
  localparam int B_ERROR = 2;
  localparam int B_FIFO_HAS_PACKET = 1;
  localparam int B_READY = 0;

  // ==========================================================
  // reset values and limits
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [LIMW-1:0] LIM_MIN = 5'h02;
  localparam logic [LIMW-1:0] LIM_MAX = 5'h10;
  localparam logic [1:0] TRY_LAST = 2'h2;

  // ==========================================================
  // per-endpoint carriers
  typedef struct packed {
    logic tx_done;
    logic ack_ok;
    logic stall_rx;
    logic no_handshake;
    logic bulk_nak_timeout;
    logic hb_no_response;
    logic bulk_int_mode;
    logic double_buf;
  } usbhtx_evt_s;

  typedef struct packed {
    logic packet_ready;
    logic setup_token;
    logic data_toggle;
    logic flush_one;
    logic flush_all;
    logic abort_load;
    logic dma_stop;
  } usbhtx_ctl_s;

endpackage

// File: dv/tb.sv
// Purpose: self-checking bench of the host transmit endpoint block
// Assumes: classic Wishbone master, one bus cycle at a time
// Notes: register rows first, then link event cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  typedef struct {logic [8:0] wi; logic [7:0] wd; logic [8:0] ri;
    logic [7:0] ex;} usbhtx_row_s;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic frame_tick = 1'b0, token = 1'b0, nak_mode = 1'b1;
  usbhtx_pkg::usbhtx_evt_s [usbhtx_pkg::NEP-1:0] ep_evt = '0;
  usbhtx_pkg::usbhtx_ctl_s [usbhtx_pkg::NEP-1:0] ep_ctl;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ep0_nak_rx, ep0_other_rx, ep0_halt, irq;
  logic [7:0] rd;
  int fail_count = 0, tests_run = 0;
  int nk [2] = '{3, 2};
  usbhtx_row_s rows [10] = '{'{9'h000, 8'h00, 9'h10b, 8'h00},
    '{9'h10b, 8'hff, 9'h10b, 8'h1f}, '{9'h000, 8'h00, 9'h132, 8'h00},
    '{9'h112, 8'h40, 9'h112, 8'h00}, '{9'h112, 8'h01, 9'h112, 8'h03},
    '{9'h112, 8'h08, 9'h112, 8'h00}, '{9'h112, 8'h11, 9'h112, 8'h13},
    '{9'h122, 8'h00, 9'h140, 8'h02}, '{9'h141, 8'h0f, 9'h140, 8'h00},
    '{9'h150, 8'h5a, 9'h150, 8'h00}};
  always #5 ref_clk = ~ref_clk;
  usbhtx_ctrl i_usbhtx_ctrl (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .frame_tick, .ep0_nak_rx, .ep0_other_rx, .ep0_halt, .ep_evt, .ep_ctl,
    .irq);
  usbhtx_target i_usbhtx_target (.ref_clk, .rstn, .token, .nak_mode,
    .ep0_nak_rx, .ep0_other_rx);
  // ==========================================================
  // tasks
  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [8:0] i,
      input logic [7:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <=
      {2'b11, w, s, 1'b0, i, 2'b00, 24'h0, d};
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge ref_clk);
    rd = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n == 20) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [8:0] i, input logic [7:0] d);
    wb(1'b1, i, d, 4'h1);
  endtask
  task automatic rc(input logic [8:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00, 4'h1);
    `CHK("reg", e, rd)
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse(input int k);
    logic [7:0] b;
    b = 8'h01 << k;
    @(posedge ref_clk);
    ep_evt <= ep_evt | {3{b}};
    @(posedge ref_clk);
    ep_evt <= ep_evt & ~{3{b}};
  endtask
  task automatic frames(input int n, input logic nak);
    repeat (n) begin
      @(posedge ref_clk);
      {nak_mode, token} <= {nak, 1'b1};
      @(posedge ref_clk);
      token <= 1'b0;
      repeat (2) @(posedge ref_clk);
      frame_tick <= 1'b1;
      @(posedge ref_clk);
      frame_tick <= 1'b0;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (rows[r]) begin
      if (rows[r].wi != 9'h000) wr(rows[r].wi, rows[r].wd);
      rc(rows[r].ri, rows[r].ex);
    end
    `CHK("setup", 1'b1, ep_ctl[0].setup_token)
    pulse(7);
    rc(9'h112, 8'h00);
    rc(9'h140, 8'h02);
    wr(9'h112, 8'h01);
    pulse(5);
    rc(9'h112, 8'h20);
    wr(9'h112, 8'h20);
    rc(9'h112, 8'h20);
    wr(9'h112, 8'h00);
    rc(9'h112, 8'h00);
    ep_evt <= {3{8'h02}};
    wr(9'h112, 8'h01);
    repeat (2) pulse(4);
    rc(9'h112, 8'h03);
    pulse(4);
    rc(9'h112, 8'h04);
    wr(9'h112, 8'h00);
    foreach (nk[j]) begin
      wr(9'h112, 8'h01);
      pulse(nk[j]);
      rc(9'h112, 8'h83);
      `CHK("ready", 1'b0, ep_ctl[0].packet_ready)
      wr(9'h112, 8'h01);
      settle();
      `CHK("ready", 1'b1, ep_ctl[0].packet_ready)
    end
    pulse(6);
    settle();
    `CHK("toggle", 1'b1, ep_ctl[0].data_toggle)
    wr(9'h112, 8'h40);
    settle();
    `CHK("toggle", 1'b0, ep_ctl[0].data_toggle)
    pulse(6);
    wr(9'h112, 8'h11);
    settle();
    `CHK("toggle", 1'b0, ep_ctl[0].data_toggle)
    `CHK("setup", 1'b1, ep_ctl[0].setup_token)
    wr(9'h112, 8'h08);
    ep_evt <= {3{8'h03}};
    wr(9'h112, 8'h01);
    rc(9'h112, 8'h02);
    wr(9'h112, 8'h01);
    rc(9'h112, 8'h03);
    repeat (2) wr(9'h112, 8'h08);
    rc(9'h112, 8'h00);
    wr(9'h112, 8'h09);
    wr(9'h142, 8'h01);
    for (int m = 2; m <= 3; m++) begin
      wr(9'h10b, 8'(m));
      frames(1 << (m - 1), 1'b1);
      settle();
      `CHK("halt", 1'b0, ep0_halt)
      frames(1, 1'b1);
      settle();
      `CHK("halt", 1'b1, ep0_halt)
    end
    `CHK("irq", 1'b1, irq)
    wr(9'h142, 8'h00);
    settle();
    `CHK("irq", 1'b0, irq)
    wr(9'h10b, 8'h02);
    frames(2, 1'b1);
    frames(1, 1'b0);
    frames(2, 1'b1);
    settle();
    `CHK("halt", 1'b0, ep0_halt)
    wr(9'h10b, 8'h01);
    frames(3, 1'b1);
    settle();
    `CHK("halt", 1'b0, ep0_halt)
    wb(1'b1, 9'h10b, 8'h05, 4'h0);
    rc(9'h10b, 8'h01);
    wr(9'h10b, 8'h02);
    wr(9'h142, 8'h01);
    frames(3, 1'b1);
    settle();
    `CHK("halt", 1'b1, ep0_halt)
    `CHK("irq", 1'b1, irq)
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    `CHK("halt", 1'b0, ep0_halt)
    `CHK("irq", 1'b0, irq)
    rc(9'h112, 8'h00);
    rc(9'h10b, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire

// File: dv/usbhtx_assertions.sv
// Purpose: port-level checks of the host transmit endpoint block
// Assumes: one clock, rstn async active low
// Notes: endpoint 1 controls are watched; bind at the foot
`timescale 1ns/1ps
`default_nettype none
module usbhtx_chk #(
  parameter int AW = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // link
  input wire logic frame_tick,
  input wire logic ep0_halt,
  input wire usbhtx_pkg::usbhtx_evt_s [usbhtx_pkg::NEP-1:0] ep_evt,
  input wire usbhtx_pkg::usbhtx_ctl_s [usbhtx_pkg::NEP-1:0] ep_ctl
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // write to the endpoint 1 low byte, landing at the ack edge
  sequence s_csr_wr;
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
      wb_adr_i[10:2] == usbhtx_pkg::IDX_TX[0];
  endsequence
  chk_stall_flush: assert property (ep_evt[0].stall_rx |=>
    ep_ctl[0].flush_all && ep_ctl[0].dma_stop && !ep_ctl[0].packet_ready)
    else $error("stall did not flush");
  chk_done_clear: assert property (ep_evt[0].tx_done &&
    !ep_evt[0].double_buf |=> !ep_ctl[0].packet_ready)
    else $error("ready held after transmit");
  chk_setup_dt: assert property ($rose(ep_ctl[0].setup_token)
    |-> !ep_ctl[0].data_toggle) else $error("setup kept toggle");
  chk_halt_tick: assert property ($rose(ep0_halt)
    |-> $past(frame_tick)) else $error("halt off a frame tick");
  chk_flush_one: assert property (s_csr_wr ##0 wb_dat_i[3]
    |=> ep_ctl[0].flush_one) else $error("flush write ignored");
  chk_abort_load: assert property (s_csr_wr ##0
    (wb_dat_i[3] && wb_dat_i[0]) |=> ep_ctl[0].abort_load)
    else $error("abort missing");
  chk_flush_cause: assert property ($rose(ep_ctl[0].flush_all)
    |-> $past(ep_evt[0].stall_rx || ep_evt[0].no_handshake))
    else $error("flush all without cause");
  chk_toggle_clr: assert property (s_csr_wr ##0 wb_dat_i[6]
    |=> !ep_ctl[0].data_toggle) else $error("toggle not cleared");
endmodule
bind usbhtx_ctrl usbhtx_chk #(.AW(AW)) i_usbhtx_chk (.ref_clk, .rstn,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .frame_tick, .ep0_halt, .ep_evt, .ep_ctl);
`default_nettype wire

// File: dv/usbhtx_target.sv
// Purpose: target device answering endpoint 0 tokens
// Assumes: one token pulse per frame from the bench
// Notes: answer comes one cycle after the token
`timescale 1ns/1ps
`default_nettype none
module usbhtx_target (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // token and answer choice
  input wire logic token,
  input wire logic nak_mode,
  // handshake answers
  output logic ep0_nak_rx,
  output logic ep0_other_rx
);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ep0_nak_rx <= 1'b0;
      ep0_other_rx <= 1'b0;
    end else begin
      ep0_nak_rx <= token && nak_mode;
      ep0_other_rx <= token && !nak_mode;
    end
  end
endmodule
`default_nettype wire
